/* File: src/vetc_top.sv */
// Video timing and start-up control with an AXI4-Lite register port.
//
// Summary of operation
// RULE_01: Mode 001 drives embedded H, V, F flags on line, blank, field pins.
// RULE_02: Mode 010: field change while line sync low starts a new frame.
// RULE_03: Modes 1-3 without blank input: blank standard blanked lines internally.
// RULE_04: Mode 011 drives line and field; pixels latch on edge after strobes.
// RULE_05: Mode 100: line and vertical sync falling together start odd field.
// RULE_06: Mode 2: vertical sync falling with line sync high starts even field.
// RULE_07: Mode 101 drives line and vertical sync with same field encoding.
// RULE_08: Mode 11x: field change while line sync high starts a new frame; mode 111 output changes field on the edge where line sync falls.
// RULE_09: Reset clears everything and leaves the pixel bus deselected.
// RULE_10: After reset run the pin-selected standard, preload its subcarrier value.
// RULE_11: Registers reset to 00H, except DAC mode 07H and second mode 08H.
// RULE_12: During reset DACs A-C are off and DACs D-F are on.
// RULE_13: Reset clears pixel enable; timing then follows the standard pin.
// RULE_14: Until pixel enable, send black and keep output strobes suppressed.
// RULE_15: Pixel enable passes pixels, drives strobes, timing follows registers.
// RULE_16: Standard override takes the standard from the first mode register.
// RULE_17: Lock and standard pins high at reset start sleep; select bit hands over.
// RULE_18: Default mode resets subcarrier phase every 4 NTSC or 8 PAL fields.
// RULE_19: Lower subcarrier bit alone: no periodic reset, only on applied pulse.
// RULE_20: An applied phase reset takes effect at the next field boundary.
// RULE_21: Drive composite, line and frame syncs; shared pin chosen by select bit.
// RULE_22: Mode 000 takes all timing from embedded codes; source holds pins high.
// RULE_23: A configuration bit enables the blank input in modes 1 to 3.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module vetc_top
    import vetc_pkg::*;
#(
    parameter logic [31:0] SCFREQ_NTSC_VAL = SCFREQ_NTSC,
    parameter logic [31:0] SCFREQ_PAL_VAL  = SCFREQ_PAL
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  pixelBus,
    input  wire vetc_sync_s  syncIn,
    output vetc_sync_s       syncOut,
    output vetc_sync_s       syncOe,
    input  wire logic        standardSelectPin,
    input  wire logic        subcarrierLockPin,
    output logic [7:0]       pixelData,
    output logic             pixelSelect,
    output logic [5:0]       dacPowerOn,
    output logic             pedestalEnable,
    output logic             sleepMode,
    output logic             standardPal,
    output logic [31:0]      scFreq,
    output logic             scPhaseReset,
    output logic             syncPinOut,
    output logic             frameSyncOut
);

    // ****************************************************************
    // Registers and AXI4-Lite slave
    // ****************************************************************
    logic [7:0]  mode0_r, mode1_r, mode2_r, mode4_r;
    logic [7:0]  mode6_r, mode7_r, timing0_r;
    logic [31:0] scFreq_r;
    logic [7:0]  awAddr_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;
    logic        awHeld_r, wHeld_r;
    logic        doWrite, wrHit, rdHit;
    logic        strapDone_r, sleepStrap_r, fieldSecond_r;
    logic [2:0]  fieldPhase_r;
    logic [31:0] rdValue;

    assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign doWrite       = awHeld_r && wHeld_r && !s_axi_bvalid;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r  <= 32'h0000_0000;
            wStrb_r  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld_r <= 1'b0;
            end
        end
    end

    always_comb begin
        case (awAddr_r)
            ADDR_MODE0, ADDR_MODE1, ADDR_MODE2, ADDR_MODE4,
            ADDR_MODE6, ADDR_MODE7, ADDR_TIMING0, ADDR_SCFREQ,
            ADDR_STATUS: wrHit = 1'b1;
            default:     wrHit = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Eight-bit registers take byte lane 0; the status word is read-only.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode0_r   <= RST_ZERO; // RULE_11
            mode1_r   <= RST_MODE1; // RULE_12
            mode2_r   <= RST_MODE2; // RULE_13
            mode4_r   <= RST_ZERO;
            mode6_r   <= RST_ZERO;
            mode7_r   <= RST_ZERO;
            timing0_r <= RST_ZERO;
        end else if (doWrite && wStrb_r[0]) begin
            case (awAddr_r)
                ADDR_MODE0:   mode0_r   <= wData_r[7:0];
                ADDR_MODE1:   mode1_r   <= wData_r[7:0];
                ADDR_MODE2:   mode2_r   <= wData_r[7:0];
                ADDR_MODE4:   mode4_r   <= wData_r[7:0];
                ADDR_MODE6:   mode6_r   <= wData_r[7:0];
                ADDR_MODE7:   mode7_r   <= wData_r[7:0];
                ADDR_TIMING0: timing0_r <= wData_r[7:0];
                default:      mode0_r   <= mode0_r;
            endcase
        end
    end

    // The strap pins are caught on the first edge after reset release.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            strapDone_r  <= 1'b0;
            sleepStrap_r <= 1'b0;
            scFreq_r     <= RST_SCFREQ;
        end else if (!strapDone_r) begin
            strapDone_r  <= 1'b1;
            sleepStrap_r <= subcarrierLockPin && standardSelectPin; // RULE_17
            scFreq_r     <= standardSelectPin ? SCFREQ_PAL_VAL
                                              : SCFREQ_NTSC_VAL; // RULE_10
        end else if (doWrite && awAddr_r == ADDR_SCFREQ) begin
            for (int i = 0; i < 4; i++) begin
                if (wStrb_r[i]) begin
                    scFreq_r[8*i +: 8] <= wData_r[8*i +: 8];
                end
            end
        end
    end

    always_comb begin
        rdHit   = 1'b1;
        rdValue = 32'h0000_0000;
        case (s_axi_araddr)
            ADDR_MODE0:   rdValue[7:0] = mode0_r;
            ADDR_MODE1:   rdValue[7:0] = mode1_r;
            ADDR_MODE2:   rdValue[7:0] = mode2_r;
            ADDR_MODE4:   rdValue[7:0] = mode4_r;
            ADDR_MODE6:   rdValue[7:0] = mode6_r;
            ADDR_MODE7:   rdValue[7:0] = mode7_r;
            ADDR_TIMING0: rdValue[7:0] = timing0_r;
            ADDR_SCFREQ:  rdValue      = scFreq_r;
            ADDR_STATUS:  rdValue[7:0] = {1'b0, pixelSelect, sleepMode,
                                          standardPal, fieldSecond_r,
                                          fieldPhase_r};
            default:      rdHit        = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdValue;
            s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    vetc_tmode_e tmode;
    logic        pixEn, isMaster, blankInEn;
    logic [11:0] lineClks;
    logic [9:0]  frameLines, halfLines;

    assign tmode     = vetc_tmode_e'(timing0_r[2:0]);
    assign pixEn     = mode2_r[M2_PIX_EN];
    assign isMaster  = timing0_r[0];
    assign blankInEn = timing0_r[T0_BLANK_EN] && tmode != TM0_SLAVE; // RULE_23
    // Before pixel enable the pin sets the standard, then the override may.
    assign standardPal = (pixEn && mode2_r[M2_STD_OVR])
                       ? (mode0_r[1:0] != 2'b00)
                       : standardSelectPin; // RULE_13 RULE_16
    assign lineClks   = standardPal ? PAL_LINE_CLKS : NTSC_LINE_CLKS;
    assign frameLines = standardPal ? PAL_LINES : NTSC_LINES;
    assign halfLines  = standardPal ? PAL_HALF : NTSC_HALF;
    assign pedestalEnable = mode2_r[M2_PEDESTAL];
    assign dacPowerOn = mode1_r[5:0]; // RULE_12
    assign sleepMode  = mode6_r[M6_SLEEP_SEL] ? mode2_r[M2_SLEEP]
                                              : sleepStrap_r; // RULE_17
    assign scFreq = scFreq_r;

    // ****************************************************************
    // Slave alignment from pins and embedded codes
    // ****************************************************************
    vetc_sync_s  prevIn_r;
    logic [23:0] byteHist_r;
    logic        codeF_r, codeV_r, codeHit;
    logic        lineFall, vsFall, fieldChg;
    logic        frameAlign, lineAlign;
    logic [9:0]  alignLine;

    assign codeHit  = byteHist_r == CODE_PREAMBLE;
    assign lineFall = prevIn_r.lineSync && !syncIn.lineSync;
    assign vsFall   = prevIn_r.field && !syncIn.field;
    assign fieldChg = prevIn_r.field != syncIn.field;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prevIn_r   <= '1;
            byteHist_r <= 24'h000000;
            codeF_r    <= 1'b0;
            codeV_r    <= 1'b0;
        end else begin
            prevIn_r   <= syncIn;
            byteHist_r <= {byteHist_r[15:0], pixelBus};
            if (codeHit) begin
                codeF_r <= pixelBus[6];
                codeV_r <= pixelBus[5];
            end
        end
    end

    // Field 1 starts at line 0, field 2 at the half-frame line.
    always_comb begin
        frameAlign = 1'b0;
        lineAlign  = 1'b0;
        alignLine  = syncIn.field ? halfLines : 10'h000;
        case (tmode)
            TM0_SLAVE: begin
                lineAlign  = codeHit && pixelBus[4]; // RULE_22
                frameAlign = lineAlign && pixelBus[6] != codeF_r;
                alignLine  = pixelBus[6] ? halfLines : 10'h000;
            end
            TM1_SLAVE: begin
                lineAlign  = lineFall;
                frameAlign = fieldChg && !syncIn.lineSync; // RULE_02
            end
            TM2_SLAVE: begin
                lineAlign  = lineFall;
                frameAlign = vsFall; // RULE_05 RULE_06
                alignLine  = lineFall ? 10'h000 : halfLines;
            end
            TM3_SLAVE: begin
                lineAlign  = lineFall;
                frameAlign = fieldChg && syncIn.lineSync; // RULE_08
            end
            default: ;
        endcase
        if (!pixEn) begin
            lineAlign  = 1'b0; // RULE_13
            frameAlign = 1'b0;
        end
    end

    // ****************************************************************
    // Line and frame counters
    // ****************************************************************
    logic [11:0] pixCnt_r;
    logic [9:0]  lineCnt_r, lineInField;
    logic        fieldSecond, hsyncAct, hblankAct, vsyncAct, vblankAct;
    logic        blankAct, evenVsync, fieldStart;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pixCnt_r  <= 12'h000;
            lineCnt_r <= 10'h000;
        end else if (frameAlign) begin
            pixCnt_r  <= 12'h000;
            lineCnt_r <= alignLine;
        end else if (lineAlign || pixCnt_r >= lineClks - 12'h001) begin
            pixCnt_r  <= 12'h000;
            lineCnt_r <= (lineCnt_r >= frameLines - 10'h001)
                       ? 10'h000 : lineCnt_r + 10'h001;
        end else begin
            pixCnt_r <= pixCnt_r + 12'h001;
        end
    end

    assign fieldSecond = lineCnt_r >= halfLines;
    assign lineInField = fieldSecond ? lineCnt_r - halfLines : lineCnt_r;
    assign hsyncAct    = pixCnt_r < HSYNC_CLKS;
    assign hblankAct   = pixCnt_r < HBLANK_CLKS;
    assign vsyncAct    = lineInField < VSYNC_LINES;
    assign vblankAct   = lineInField < BLANK_LINES;
    // The even field's vertical sync starts once line sync is back high.
    assign evenVsync   = vsyncAct && !(lineInField == 10'h000 && hsyncAct);
    assign fieldStart  = fieldSecond != fieldSecond_r;

    always_comb begin
        if (tmode == TM0_SLAVE && pixEn) begin
            blankAct = codeV_r || hblankAct;
        end else if (blankInEn && !isMaster && pixEn) begin
            blankAct = !syncIn.blank;
        end else begin
            blankAct = hblankAct || vblankAct; // RULE_03
        end
    end

    // ****************************************************************
    // Pixel path
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pixelSelect <= 1'b0; // RULE_09
            pixelData   <= BLACK_LUMA;
        end else begin
            pixelSelect <= pixEn; // RULE_15
            if (!pixEn || blankAct) begin
                pixelData <= pixCnt_r[0] ? BLACK_LUMA
                                         : BLACK_CHROMA; // RULE_14
            end else begin
                pixelData <= pixelBus; // RULE_04
            end
        end
    end

    // ****************************************************************
    // Timing strobe pins and sync outputs
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            syncOut      <= '1;
            syncOe       <= '0;
            syncPinOut   <= 1'b1;
            frameSyncOut <= 1'b1;
        end else begin
            syncOe <= (isMaster && pixEn) ? '1 : '0; // RULE_14 RULE_15
            case (tmode)
                TM0_MASTER: begin
                    syncOut.lineSync <= hblankAct; // RULE_01
                    syncOut.blank    <= vblankAct;
                    syncOut.field    <= fieldSecond;
                end
                TM2_MASTER: begin
                    syncOut.lineSync <= !hsyncAct; // RULE_07
                    syncOut.blank    <= !blankAct;
                    syncOut.field    <= fieldSecond ? !evenVsync
                                                    : !vsyncAct;
                end
                default: begin
                    syncOut.lineSync <= !hsyncAct; // RULE_04
                    syncOut.blank    <= !blankAct;
                    syncOut.field    <= fieldSecond;
                end
            endcase
            frameSyncOut <= !(pixEn && vsyncAct); // RULE_21
            syncPinOut   <= !pixEn || (mode7_r[M7_SYNC_SEL]
                          ? !(hsyncAct ^ vsyncAct) : !hsyncAct);
        end
    end

    // ****************************************************************
    // Subcarrier phase reset
    // ****************************************************************
    logic [1:0] scMode;
    logic       lockPrev_r, resetPend_r, lockRise;

    assign scMode   = {mode4_r[M4_SC_HI], mode4_r[M4_SC_LO]};
    assign lockRise = subcarrierLockPin && !lockPrev_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fieldSecond_r <= 1'b0;
            fieldPhase_r  <= 3'h0;
            scPhaseReset  <= 1'b0;
            lockPrev_r    <= 1'b0;
            resetPend_r   <= 1'b0;
        end else begin
            fieldSecond_r <= fieldSecond;
            lockPrev_r    <= subcarrierLockPin;
            scPhaseReset  <= 1'b0;
            // A new pulse wins over the clear at the boundary.
            if (scMode == 2'b01 && lockRise) begin
                resetPend_r <= 1'b1; // RULE_19
            end else if (fieldStart || scMode != 2'b01) begin
                resetPend_r <= 1'b0;
            end
            if (fieldStart) begin
                fieldPhase_r <= fieldPhase_r + 3'h1;
                if (scMode == 2'b00 && fieldPhase_r >=
                    (standardPal ? PAL_PH_FIELDS : NTSC_PH_FIELDS)) begin
                    fieldPhase_r <= 3'h0; // RULE_18
                    scPhaseReset <= 1'b1;
                end else if (resetPend_r) begin
                    fieldPhase_r <= 3'h0; // RULE_20
                    scPhaseReset <= 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

/* File: pkg/vetc_pkg.sv */
// Package with register map, reset values and timing constants.
package vetc_pkg;
    localparam logic [7:0] ADDR_MODE0   = 8'h00;
    localparam logic [7:0] ADDR_MODE1   = 8'h04;
    localparam logic [7:0] ADDR_MODE2   = 8'h08;
    localparam logic [7:0] ADDR_MODE4   = 8'h0C;
    localparam logic [7:0] ADDR_MODE6   = 8'h10;
    localparam logic [7:0] ADDR_MODE7   = 8'h14;
    localparam logic [7:0] ADDR_TIMING0 = 8'h18;
    localparam logic [7:0] ADDR_SCFREQ  = 8'h1C;
    localparam logic [7:0] ADDR_STATUS  = 8'h20;
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [7:0] RST_MODE1    = 8'h07;
    localparam logic [7:0] RST_MODE2    = 8'h08;
    localparam logic [31:0] RST_SCFREQ  = 32'h0000_0000;
    localparam logic [31:0] SCFREQ_NTSC = 32'h0000_0001;
    localparam logic [31:0] SCFREQ_PAL  = 32'h0000_0002;
    localparam int M2_PEDESTAL  = 3;
    localparam int M2_STD_OVR   = 5;
    localparam int M2_PIX_EN    = 6;
    localparam int M2_SLEEP     = 7;
    localparam int M4_SC_LO     = 1;
    localparam int M4_SC_HI     = 2;
    localparam int M6_SLEEP_SEL = 0;
    localparam int M7_SYNC_SEL  = 5;
    localparam int T0_BLANK_EN  = 3;
    localparam logic [11:0] NTSC_LINE_CLKS = 12'h6B4;
    localparam logic [11:0] PAL_LINE_CLKS  = 12'h6C0;
    localparam logic [9:0]  NTSC_LINES     = 10'h20D;
    localparam logic [9:0]  PAL_LINES      = 10'h271;
    localparam logic [9:0]  NTSC_HALF      = 10'h107;
    localparam logic [9:0]  PAL_HALF       = 10'h139;
    localparam logic [11:0] HSYNC_CLKS     = 12'h080;
    localparam logic [11:0] HBLANK_CLKS    = 12'h110;
    localparam logic [9:0]  VSYNC_LINES    = 10'h003;
    localparam logic [9:0]  BLANK_LINES    = 10'h014;
    localparam logic [2:0]  NTSC_PH_FIELDS = 3'h3;
    localparam logic [2:0]  PAL_PH_FIELDS  = 3'h7;
    localparam logic [7:0]  BLACK_LUMA     = 8'h10;
    localparam logic [7:0]  BLACK_CHROMA   = 8'h80;
    localparam logic [23:0] CODE_PREAMBLE  = 24'hFF0000;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [2:0] {
        TM0_SLAVE  = 3'h0,
        TM0_MASTER = 3'h1,
        TM1_SLAVE  = 3'h2,
        TM1_MASTER = 3'h3,
        TM2_SLAVE  = 3'h4,
        TM2_MASTER = 3'h5,
        TM3_SLAVE  = 3'h6,
        TM3_MASTER = 3'h7
    } vetc_tmode_e;

    typedef struct packed {
        logic lineSync;
        logic blank;
        logic field;
    } vetc_sync_s;
endpackage

/* File: testbench/vetc_video_source.sv */
// Upstream video source model driving pixels and slave strobes.
`timescale 1ns/1ps
`default_nettype none
module vetc_video_source
    import vetc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [2:0] mode,
    output vetc_sync_s      syncDrv,
    output logic [7:0]      pixel
);
    logic [8:0] cnt = 9'h000;
    wire logic [7:0] lim = mode[2] ? 8'h80 : 8'h08;
    always_ff @(posedge ref_clk) begin
        cnt <= cnt + 9'h001;
        pixel <= cnt[7:0] ^ 8'hA5;
        syncDrv.blank <= 1'h1;
        syncDrv.lineSync <= mode == 3'h0 || cnt[7:4] != 4'h0;
        if (mode == 3'h4) begin
            syncDrv.field <= cnt[7:4] != (cnt[8] ? 4'h0 : 4'h4);
        end else begin
            syncDrv.field <= mode == 3'h0 || (cnt[8] ^ (cnt[7:0] >= lim));
        end
    end
endmodule
`default_nettype wire

/* File: testbench/vetc_assertions.sv */
// Port checker for the video timing controller.
`timescale 1ns/1ps
`default_nettype none
module vetc_assertions
    import vetc_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        standardSelectPin,
    input wire logic [7:0]  pixelData,
    input wire logic        pixelSelect,
    input wire vetc_sync_s  syncOe,
    input wire logic [5:0]  dacPowerOn,
    input wire logic [31:0] scFreq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    AST_BLACK:
        assert property (!pixelSelect [*2] |-> $past(pixelData) inside
            {BLACK_LUMA, BLACK_CHROMA}) else $error("not black");
    AST_STROBES_OFF:
        assert property (!pixelSelect [*2] |-> $past(syncOe) == 3'h0)
        else $error("strobes early");
    AST_DAC_DEFAULT:
        assert property ($rose(reset_n) |-> dacPowerOn == 6'h07)
        else $error("dac default");
    AST_PIX_DESELECT:
        assert property ($rose(reset_n) |-> !pixelSelect ##1 !pixelSelect)
        else $error("pixel bus selected");
    AST_SC_PRESET:
        assert property ($rose(reset_n) |=> scFreq == ($past(standardSelectPin)
            ? SCFREQ_PAL : SCFREQ_NTSC)) else $error("preset");
    AST_AW_REFUSED:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write not refused");
    AST_B_HOLD:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
            && $stable(s_axi_bresp)) else $error("response dropped");
    AST_WR_RESP:
        assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("no response");
endmodule
bind vetc_top vetc_assertions chk (.ref_clk, .reset_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .standardSelectPin, .pixelData, .pixelSelect, .syncOe,
    .dacPowerOn, .scFreq);
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the video timing controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
    import vetc_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] rst; logic [31:0] wr;} vetc_row_s;
    logic        ref_clk = 1'h0, reset_n = 1'h0, standardSelectPin = 1'h0;
    logic        subcarrierLockPin = 1'h0, s_axi_awvalid = 1'h0;
    logic        s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, pixelSelect, sleepMode, standardPal;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pixelBus, pixelData;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, scFreq, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [5:0]  dacPowerOn;
    logic        pedestalEnable, syncPinOut, frameSyncOut, scPhaseReset;
    logic [2:0]  srcMode = 3'h2;
    vetc_sync_s  srcSync, syncIn, syncOut, syncOe;
    int          miscompares = 0, n_tests = 0, nPh = 0;
    vetc_row_s   rows [8] = '{'{ADDR_MODE0, 32'h0, 32'h1},
        '{ADDR_MODE1, 32'h7, 32'h3F}, '{ADDR_MODE4, 32'h0, 32'h2},
        '{ADDR_MODE6, 32'h0, 32'h1}, '{ADDR_MODE7, 32'h0, 32'h20},
        '{ADDR_TIMING0, 32'h0, 32'hB}, '{ADDR_SCFREQ, SCFREQ_NTSC, 32'h1234},
        '{ADDR_MODE2, 32'h8, 32'h48}};
    // Pins resolve to whichever party enables its driver.
    assign syncIn = (syncOe & syncOut) | (~syncOe & srcSync);
    vetc_video_source src (.ref_clk, .mode(srcMode), .syncDrv(srcSync),
        .pixel(pixelBus));
    vetc_top dut (.ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pixelBus, .syncIn, .syncOut, .syncOe, .standardSelectPin,
        .subcarrierLockPin, .pixelData, .pixelSelect, .dacPowerOn,
        .pedestalEnable, .sleepMode, .standardPal, .scFreq, .scPhaseReset,
        .syncPinOut, .frameSyncOut);
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge ref_clk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        do begin
            @(negedge ref_clk);
            ta = w ? s_axi_awready : s_axi_arready;
            tw = s_axi_wready;
            tb = w ? s_axi_bvalid : s_axi_rvalid;
            {rs, rd} = w ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
            @(posedge ref_clk);
            if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end while (!tb);
        {s_axi_bready, s_axi_rready} <= 2'h0;
        @(negedge ref_clk);
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(negedge ref_clk) nPh <= nPh + int'(scPhaseReset);
    initial begin
        repeat (30000) @(posedge ref_clk);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'h1;
        foreach (rows[i]) begin
            xfer(1'h0, rows[i].a, 32'h0);
            `CHK(rd, rows[i].rst)
            xfer(1'h1, rows[i].a, rows[i].wr);
            xfer(1'h0, rows[i].a, 32'h0);
            `CHK({rs, rd}, {RESP_OKAY, rows[i].wr})
        end
        repeat (20) if (pixelSelect !== 1'h1) @(negedge ref_clk);
        `CHK({pixelSelect, syncOe}, 4'hF)
        for (int m = 0; m < 8; m++) begin
            @(posedge ref_clk) srcMode <= 3'(m);
            subcarrierLockPin <= (m >= 2);
            xfer(1'h1, ADDR_TIMING0, 32'(m));
            repeat (600) @(negedge ref_clk);
            `CHK(syncOe, m[0] ? 3'h7 : 3'h0)
            `CHK(nPh, int'(m >= 2))
        end
        xfer(1'h1, ADDR_MODE2, 32'h68);
        `CHK(standardPal, 1'h1)
        xfer(1'h0, 8'h24, 32'h0);
        `CHK({rs, rd}, {RESP_SLVERR, 32'h0})
        @(posedge ref_clk) reset_n <= 1'h0;
        {standardSelectPin, subcarrierLockPin} <= 2'h3;
        repeat (6) @(negedge ref_clk);
        `CHK({dacPowerOn, pixelSelect, standardPal}, 8'h1D)
        `CHK({pedestalEnable, syncPinOut, frameSyncOut}, 3'h7)
        @(posedge ref_clk) reset_n <= 1'h1;
        repeat (3) @(negedge ref_clk);
        `CHK({sleepMode, scFreq}, {1'h1, SCFREQ_PAL})
        xfer(1'h1, ADDR_MODE6, 32'h1);
        xfer(1'h1, ADDR_MODE2, 32'h0);
        `CHK(sleepMode, 1'h0)
        tally_and_finish();
    end
endmodule
`default_nettype wire
